//--- hdl/otewd_consts.svh
// Constants of the one-time-enable watchdog.
//
// Contract
// - A 14-bit counter; the service register is the only visible part.
// - After any reset the watchdog is off and its counter holds still.
// - Writing 01EH then 0E1H to service address 0A6H turns the watchdog on.
// - While on, the counter advances by one on every machine cycle.
// - Once on, software cannot turn it off; only a reset or overflow does.
// - While on, the sequence 01EH then 0E1H clears the counter to zero.
// - On reaching 3FFFH (16383) the counter overflows and resets the device.
// - On overflow the device drives the reset pin high as an output pulse.
// - Reset pulse is 98 oscillator periods in 6-clock, 196 in 12-clock mode.
// - The service register is write only; reads give no watchdog data.
// - Counter is hidden; only counting, service or reset change it.
`ifndef OTEWD_CONSTS_SVH
`define OTEWD_CONSTS_SVH

// ==========================================================
// Register map and service keys.
`define OTEWD_SVC_ADDR 8'hA6
`define OTEWD_KEY_FIRST 8'h1E
`define OTEWD_KEY_SECOND 8'hE1
`define OTEWD_RDATA_IDLE 8'h00

// ==========================================================
// Counter layout.
`define OTEWD_CNT_W 14
`define OTEWD_CNT_RESET 14'h0000
`define OTEWD_CNT_TERM 14'h3FFF

// ==========================================================
// Timing: the core clock is the oscillator.
`define OTEWD_OSC_PERIOD_NS 50
`define OTEWD_CLK_PERIOD_NS 50
`define OTEWD_MC6_OSC 6
`define OTEWD_MC12_OSC 12
`define OTEWD_PULSE6_OSC 98
`define OTEWD_PULSE12_OSC 196
`define OTEWD_MC6_CYC \
    ((`OTEWD_MC6_OSC * `OTEWD_OSC_PERIOD_NS) / `OTEWD_CLK_PERIOD_NS)
`define OTEWD_MC12_CYC \
    ((`OTEWD_MC12_OSC * `OTEWD_OSC_PERIOD_NS) / `OTEWD_CLK_PERIOD_NS)
`define OTEWD_PULSE6_CYC \
    ((`OTEWD_PULSE6_OSC * `OTEWD_OSC_PERIOD_NS) / `OTEWD_CLK_PERIOD_NS)
`define OTEWD_PULSE12_CYC \
    ((`OTEWD_PULSE12_OSC * `OTEWD_OSC_PERIOD_NS) / `OTEWD_CLK_PERIOD_NS)
`define OTEWD_DIV_W 4
`define OTEWD_PULSE_W 8

`endif

//--- hdl/otewd_pkg.sv
// Types of the one-time-enable watchdog.
`default_nettype none

package otewd_pkg;

    // ======================================================
    // Watchdog states, one-hot.
    typedef enum logic [2:0] {
        WD_OFF = 3'b001,
        WD_RUN = 3'b010,
        WD_PULSE = 3'b100
    } otewd_state_t;

    // ======================================================
    // Service sequence states, one-hot.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_ARMED = 2'b10
    } otewd_seq_t;

endpackage

`default_nettype wire

//--- hdl/otewd_top.sv
// One-time-enable watchdog with service register and reset-out pulse.
`include "otewd_consts.svh"
`default_nettype none

module otewd_top
    import otewd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_mode6_in,
    input wire logic sfr_wr_en_in,
    input wire logic sfr_rd_en_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    output logic dev_reset_out,
    output logic rst_pin_out,
    output logic rst_pin_oe_n_out
);

    // ======================================================
    // Declarations.
    otewd_state_t state_r;
    otewd_state_t state_nxt;
    otewd_seq_t seq_r;
    logic [`OTEWD_CNT_W-1:0] cnt_r;
    logic [`OTEWD_DIV_W-1:0] div_r;
    logic [`OTEWD_PULSE_W-1:0] pulse_r;
    logic svc_wr;
    logic seq_done;
    logic mc_tick;
    logic overflow;
    logic pulse_end;
    logic [`OTEWD_DIV_W-1:0] div_last;
    logic [`OTEWD_PULSE_W-1:0] pulse_load;

    // ======================================================
    // Service register decode.
    assign svc_wr = sfr_wr_en_in && (sfr_addr_in == `OTEWD_SVC_ADDR);
    assign seq_done = svc_wr && (seq_r == SEQ_ARMED) &&
        (sfr_wdata_in == `OTEWD_KEY_SECOND);

    // ======================================================
    // Machine cycle divider.
    assign div_last = clk_mode6_in ?
        `OTEWD_DIV_W'(`OTEWD_MC6_CYC - 1) :
        `OTEWD_DIV_W'(`OTEWD_MC12_CYC - 1);
    assign mc_tick = (div_r >= div_last);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= '0;
        end else if (mc_tick || state_r != WD_RUN) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + `OTEWD_DIV_W'(1);
        end
    end

    // ======================================================
    // Overflow detection and pulse length.
    assign overflow = (state_r == WD_RUN) &&
        (cnt_r == `OTEWD_CNT_TERM);
    assign pulse_load = clk_mode6_in ?
        `OTEWD_PULSE_W'(`OTEWD_PULSE6_CYC - 1) :
        `OTEWD_PULSE_W'(`OTEWD_PULSE12_CYC - 1);
    assign pulse_end = (pulse_r == '0);

    // ======================================================
    // Watchdog state machine.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            WD_OFF: begin
                if (seq_done) begin
                    state_nxt = WD_RUN;
                end
            end
            WD_RUN: begin
                if (overflow) begin
                    state_nxt = WD_PULSE;
                end
            end
            WD_PULSE: begin
                if (pulse_end) begin
                    state_nxt = WD_OFF;
                end
            end
            default: begin
                state_nxt = WD_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= WD_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ======================================================
    // Service sequence tracker.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seq_r <= SEQ_IDLE;
        end else if (state_r == WD_PULSE) begin
            seq_r <= SEQ_IDLE;
        end else if (svc_wr) begin
            if (seq_r == SEQ_IDLE && sfr_wdata_in == `OTEWD_KEY_FIRST) begin
                seq_r <= SEQ_ARMED;
            end else begin
                seq_r <= SEQ_IDLE;
            end
        end
    end

    // ======================================================
    // Watchdog counter, changed only by counting, service or reset.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= `OTEWD_CNT_RESET;
        end else if (state_r != WD_RUN || overflow) begin
            cnt_r <= `OTEWD_CNT_RESET;
        end else if (seq_done) begin
            cnt_r <= `OTEWD_CNT_RESET;
        end else if (mc_tick) begin
            cnt_r <= cnt_r + `OTEWD_CNT_W'(1);
        end
    end

    // ======================================================
    // Reset pulse length counter.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_r <= '0;
        end else if (overflow) begin
            pulse_r <= pulse_load;
        end else if (state_r == WD_PULSE && !pulse_end) begin
            pulse_r <= pulse_r - `OTEWD_PULSE_W'(1);
        end
    end

    // ======================================================
    // Outputs.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_reset_out <= 1'b0;
            rst_pin_out <= 1'b0;
            rst_pin_oe_n_out <= 1'b1;
        end else begin
            dev_reset_out <= (state_nxt == WD_PULSE);
            rst_pin_out <= (state_nxt == WD_PULSE);
            rst_pin_oe_n_out <= (state_nxt != WD_PULSE);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= `OTEWD_RDATA_IDLE;
        end else if (sfr_rd_en_in) begin
            sfr_rdata_out <= `OTEWD_RDATA_IDLE;
        end
    end

    // ======================================================
    // Assertion helpers.
    logic [`OTEWD_PULSE_W:0] hi_len_r;
    logic mode6_at_ovf_r;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_len_r <= '0;
            mode6_at_ovf_r <= 1'b0;
        end else begin
            if (rst_pin_out) begin
                hi_len_r <= hi_len_r + (`OTEWD_PULSE_W+1)'(1);
            end else begin
                hi_len_r <= '0;
            end
            if (overflow) begin
                mode6_at_ovf_r <= clk_mode6_in;
            end
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ======================================================
    // Assertions.
    off_still_a: assert property (
        state_r == WD_OFF |-> cnt_r == `OTEWD_CNT_RESET
    ) else $error("Counter moved while watchdog off.");

    enable_seq_a: assert property (
        state_r == WD_OFF && seq_r == SEQ_ARMED && svc_wr &&
        sfr_wdata_in == `OTEWD_KEY_SECOND |=> state_r == WD_RUN
    ) else $error("Enable sequence did not start watchdog.");

    count_step_a: assert property (
        state_r == WD_RUN && mc_tick && !seq_done && !overflow
        |=> cnt_r == $past(cnt_r) + `OTEWD_CNT_W'(1)
    ) else $error("Counter did not advance on machine cycle.");

    mc_period_a: assert property (
        state_r == WD_RUN && mc_tick && clk_mode6_in ##1
        (state_r == WD_RUN && clk_mode6_in && !mc_tick) [*5]
        |=> mc_tick || state_r != WD_RUN || !clk_mode6_in
    ) else $error("Machine cycle not six clocks.");

    no_disable_a: assert property (
        state_r == WD_RUN |=> state_r != WD_OFF
    ) else $error("Watchdog turned off without reset.");

    service_clr_a: assert property (
        state_r == WD_RUN && seq_done && !overflow
        |=> cnt_r == `OTEWD_CNT_RESET
    ) else $error("Service did not clear counter.");

    overflow_rst_a: assert property (
        state_r == WD_RUN && cnt_r == `OTEWD_CNT_TERM
        |=> dev_reset_out && state_r == WD_PULSE
    ) else $error("Overflow did not reset device.");

    pin_drive_a: assert property (
        rst_pin_out |-> !rst_pin_oe_n_out && dev_reset_out
    ) else $error("Reset pin high but not driven.");

    pulse_len_a: assert property (
        $fell(rst_pin_out) |-> hi_len_r == (mode6_at_ovf_r ?
            `OTEWD_PULSE6_CYC : `OTEWD_PULSE12_CYC)
    ) else $error("Reset pulse length wrong.");

    read_blank_a: assert property (
        sfr_rd_en_in |=> sfr_rdata_out == `OTEWD_RDATA_IDLE
    ) else $error("Read returned watchdog data.");

    bad_key_a: assert property (
        seq_r == SEQ_ARMED && svc_wr && sfr_wdata_in != `OTEWD_KEY_SECOND
        && state_r != WD_PULSE && !overflow
        |=> seq_r == SEQ_IDLE && $stable(state_r)
    ) else $error("Bad key did not drop sequence.");

    // ======================================================
    // Coverage.
    enable_c: cover property (state_r == WD_OFF ##1 state_r == WD_RUN);
    service_c: cover property (state_r == WD_RUN && seq_done);
    overflow_c: cover property ($fell(rst_pin_out));
    abort_c: cover property (seq_r == SEQ_ARMED ##1 seq_r == SEQ_IDLE
        && !$past(seq_done));

endmodule

`default_nettype wire

//--- tb/otewd_board_model.sv
// Board model: reset button, reset pin with pull-down, pulse width meter.
`default_nettype none

module otewd_board_model (
    input wire logic core_clk_in,
    input wire logic hold_in,
    input wire logic pin_drv_in,
    input wire logic pin_oe_n_in,
    output logic rst_n_out,
    output logic pin_level_out,
    output logic [8:0] width_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [8:0] run_r;

    // ==========================================================
    // Board reset line and resolved reset pin.
    assign rst_n_out = ~hold_in;
    assign pin_level_out = pin_oe_n_in ? 1'b0 : pin_drv_in;

    // ==========================================================
    // Width of each high pulse on the pin, in clocks.
    initial begin
        run_r = 9'h000;
        width_out = 9'h000;
    end

    always @(posedge core_clk_in) begin
        if (pin_level_out === 1'b1) begin
            run_r <= run_r + 9'h001;
        end else begin
            if (run_r != 9'h000) begin
                width_out <= run_r;
            end
            run_r <= 9'h000;
        end
    end
endmodule

`default_nettype wire

//--- tb/otewd_tb_top.sv
// Self-checking bench of the one-time-enable watchdog.
`include "otewd_consts.svh"
`default_nettype none

module otewd_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int dly = 5;
    localparam int limit = 101000;
    localparam int ovf_cyc = `OTEWD_CNT_TERM * `OTEWD_MC6_CYC;
    localparam logic [7:0] sa = `OTEWD_SVC_ADDR;
    localparam logic [7:0] k1 = `OTEWD_KEY_FIRST;
    localparam logic [7:0] k2 = `OTEWD_KEY_SECOND;

    logic core_clk, hold, mode6, wr_en, rd_en, rst_n, early;
    logic dev_rst, pin_out, pin_oe_n, pin_lvl;
    logic [7:0] addr, wdata, rdata;
    logic [8:0] pin_w;
    int err_total, cmp_count, cyc, tcnt, dev_w;

    otewd_top u_dut (
        .core_clk_in(core_clk),
        .rst_n_in(rst_n),
        .clk_mode6_in(mode6),
        .sfr_wr_en_in(wr_en),
        .sfr_rd_en_in(rd_en),
        .sfr_addr_in(addr),
        .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata),
        .dev_reset_out(dev_rst),
        .rst_pin_out(pin_out),
        .rst_pin_oe_n_out(pin_oe_n)
    );

    otewd_board_model u_board (
        .core_clk_in(core_clk),
        .hold_in(hold),
        .pin_drv_in(pin_out),
        .pin_oe_n_in(pin_oe_n),
        .rst_n_out(rst_n),
        .pin_level_out(pin_lvl),
        .width_out(pin_w)
    );

    // ==========================================================
    // Clock and hang limit.
    initial begin
        core_clk = 1'b0;
        forever #(`OTEWD_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc >= limit) begin
            err_total++;
            give_verdict();
        end
    end

    // ==========================================================
    // Tasks.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #dly;
        tcnt++;
        if (dev_rst !== 1'b0) begin
            early = 1'b1;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        step();
    endtask

    task automatic idle(input int n);
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (n) step();
    endtask

    task automatic rd(input logic [7:0] a);
        wr_en = 1'b0;
        rd_en = 1'b1;
        addr = a;
        step();
        idle(1);
        chk(16'(rdata), 16'h0000);
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        hold = 1'b1;
        mode6 = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        early = 1'b0;
        repeat (12) @(posedge core_clk);
        #dly;
        chk(16'({dev_rst, pin_out, pin_oe_n, rdata}), 16'h0100);
        hold = 1'b0;
        idle(2);
        rd(sa);
        wr(sa, k1);
        wr(sa, k2);
        idle(30);
        hold = 1'b1;
        idle(3);
        hold = 1'b0;
        idle(2);
        chk(16'({dev_rst, pin_out, pin_oe_n}), 16'h0001);
        wr(sa, k1);
        wr(sa, 8'h55);
        wr(sa, k2);
        wr(sa, k1);
        wr(sa, k1);
        wr(sa, k2);
        wr(8'hA7, k1);
        wr(sa, k2);
        idle(42);
        wr(sa, k1);
        wr(sa, k2);
        idle(100);
        wr(sa, 8'h00);
        wr(sa, 8'hFF);
        rd(sa);
        rd(8'h80);
        idle(100);
        wr(sa, k1);
        idle(2);
        wr(sa, k2);
        tcnt = 0;
        idle(50);
        wr(sa, k1);
        wr(sa, 8'h00);
        wr(sa, k2);
        idle(ovf_cyc - tcnt);
        chk(16'(early), 16'h0000);
        mode6 = 1'b0;
        step();
        chk(16'({dev_rst, pin_out}), 16'h0003);
        chk(16'({pin_oe_n, pin_lvl}), 16'h0001);
        dev_w = 0;
        while (dev_rst === 1'b1 && dev_w < 400) begin
            dev_w++;
            step();
        end
        chk(16'(dev_w), 16'(`OTEWD_PULSE12_CYC));
        idle(2);
        chk(16'(pin_w), 16'(`OTEWD_PULSE12_CYC));
        chk(16'({pin_out, pin_oe_n, pin_lvl}), 16'h0002);
        give_verdict();
    end
endmodule

`default_nettype wire
